// >>> logic/pscfg_port.sv
// Passive-serial configuration port: request/status handshake, serial load,
// start-up timing and chain enable.
// Assumes pins other than crc_error_i and use_user_clock_i are asynchronous to ref_clk_i, which runs at 10 MHz.
// Function
// - User mode: lines high; low request reconfigures.
// - Status held low during power-on delay.
// - Done low until configuration completes.
// - Request low pulls done low quickly.
// - Request low drives status low quickly.
// - Status low between 45 and 230 us.
// - Status released within 230 us.
// - Oscillator start-up: user mode 300-650 us.
// - User clock used four periods after done.
// - User clock path adds initialization cycles.
// - Chain enable out feeds next enable in.
// - Chained devices initialise together on shared done.
// - Detected error pulls shared status low.
// - Data sampled on serial clock rising edge.
// - Init-complete line released on user mode.
`timescale 1ns/10ps
`default_nettype none
module pscfg_port
  import pscfg_pkg::*;
#(
  parameter int unsigned STREAM_BITS = 64,
  parameter int unsigned POR_CYCLES = POR_CYC,
  parameter int unsigned STATUS_CYCLES = STATUS_LOW_CYC,
  parameter int unsigned STARTUP_CYCLES = CD2UM_CYC,
  parameter int unsigned INIT_CYCLES = INIT_USER_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic reconfig_req_n_i,
  input wire logic status_n_i,
  output logic status_n_o,
  output logic status_n_oe_o,
  input wire logic cfg_done_i,
  output logic cfg_done_o,
  output logic cfg_done_oe_o,
  input wire logic cfg_serial_clock_i,
  input wire logic cfg_data_i,
  input wire logic chain_en_n_i,
  output logic chain_en_n_o,
  input wire logic user_startup_clock_i,
  input wire logic use_user_clock_i,
  input wire logic crc_error_i,
  output logic init_done_o,
  output logic init_done_oe_o,
  output logic user_mode_o,
  output logic [7:0] cfg_byte_o,
  output logic cfg_byte_valid_o
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic req_lvl;
  logic req_fall;
  logic sts_lvl;
  logic done_lvl;
  logic cfg_serial_clock_rise;
  logic cfg_serial_clock_fall;
  logic data_lvl;
  logic ce_lvl;
  logic uclk_rise;

  pscfg_sync #(.RST_VAL(1'b1)) u_req (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .pin_i(reconfig_req_n_i), .level_o(req_lvl), .rise_o(), .fall_o(req_fall));
  pscfg_sync #(.RST_VAL(1'b0)) u_sts (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .pin_i(status_n_i), .level_o(sts_lvl), .rise_o(), .fall_o());
  pscfg_sync #(.RST_VAL(1'b0)) u_done (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .pin_i(cfg_done_i), .level_o(done_lvl), .rise_o(), .fall_o());
  pscfg_sync #(.RST_VAL(1'b0)) u_cfg_serial_clock (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .pin_i(cfg_serial_clock_i), .level_o(), .rise_o(cfg_serial_clock_rise), .fall_o(cfg_serial_clock_fall));
  pscfg_sync #(.RST_VAL(1'b0)) u_data (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .pin_i(cfg_data_i), .level_o(data_lvl), .rise_o(), .fall_o());
  pscfg_sync #(.RST_VAL(1'b1)) u_ce (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .pin_i(chain_en_n_i), .level_o(ce_lvl), .rise_o(), .fall_o());
  pscfg_sync #(.RST_VAL(1'b0)) u_uclk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .pin_i(user_startup_clock_i), .level_o(), .rise_o(uclk_rise), .fall_o());

  // ---------------------------------------------------------------------------
  // State and counters
  // ---------------------------------------------------------------------------
  pscfg_state_t state_q;
  pscfg_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [31:0] bits_q;
  logic [2:0] bitpos_q;
  logic [7:0] shift_q;
  logic [1:0] falls_q;
  logic use_uclk_q;
  logic sts_drive_q;
  logic done_drive_q;
  logic init_drive_q;
  logic user_q;
  logic ceo_n_q;
  logic [7:0] byte_q;
  logic byte_vld_q;

  // Loading proceeds only while status is released and the chain enables us.
  // A synchronised edge costs a few reference cycles of latency, so the
  // serial clock must stay far below the reference rate in this model.
  logic load_ok;
  logic take_bit;
  logic load_end;
  logic cnt_zero;

  assign load_ok = sts_lvl && !ce_lvl;
  assign take_bit = (state_q == PSCFG_LOAD) && load_ok && cfg_serial_clock_rise;
  assign load_end = take_bit && (bits_q == STREAM_BITS - 1);
  assign cnt_zero = (cnt_q == '0);

  // ---------------------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
    unique case (state_q)
      PSCFG_POR: begin
        if (cnt_zero) begin
          state_d = PSCFG_RESET;
          cnt_d = CNT_W'(STATUS_CYCLES);
        end
      end
      PSCFG_RESET: begin
        // Status stays low at least the minimum, longer while request is low.
        if (cnt_zero && req_lvl) begin
          state_d = PSCFG_LOAD;
        end
      end
      PSCFG_LOAD: begin
        // An error halts loading at once; waiting for the synchronised status
        // level would leave the shared line released for several cycles.
        if (crc_error_i && !ce_lvl) begin
          state_d = PSCFG_ERROR;
        end else if (load_end) begin
          state_d = PSCFG_WAIT_EDGES;
        end
      end
      PSCFG_WAIT_EDGES: begin
        // Shared done must read high before counting start-up edges.
        if (done_lvl && cfg_serial_clock_fall && falls_q == 2'd1) begin
          state_d = PSCFG_INIT;
          cnt_d = use_uclk_q ? CNT_W'(CD2CU_REF_CYC + INIT_CYCLES)
                             : CNT_W'(STARTUP_CYCLES);
        end
      end
      PSCFG_INIT: begin
        // With the user clock, the wait counts its edges after the enable delay.
        if (use_uclk_q && cnt_q <= CNT_W'(INIT_CYCLES) && !uclk_rise) begin
          cnt_d = cnt_q;
        end
        if (cnt_zero) begin
          state_d = PSCFG_USER;
        end
      end
      PSCFG_USER: begin
      end
      PSCFG_ERROR: begin
      end
    endcase
    // A low request overrides every state except PSCFG_POR and restarts the cycle.
    if (!req_lvl && state_q != PSCFG_POR) begin
      state_d = PSCFG_RESET;
      cnt_d = CNT_W'(STATUS_CYCLES);
    end
  end

  // ---------------------------------------------------------------------------
  // State, counters and serial shifter
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= PSCFG_POR;
      cnt_q <= CNT_W'(POR_CYCLES);
      bits_q <= '0;
      bitpos_q <= '0;
      shift_q <= '0;
      falls_q <= '0;
      use_uclk_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_q == PSCFG_RESET) begin
        bits_q <= '0;
        bitpos_q <= '0;
        falls_q <= '0;
        use_uclk_q <= use_user_clock_i;
      end else if (take_bit) begin
        // First bit of each byte lands in bit 0.
        shift_q <= {data_lvl, shift_q[7:1]};
        bitpos_q <= bitpos_q + 3'd1;
        bits_q <= bits_q + 32'd1;
      end
      if (state_q == PSCFG_WAIT_EDGES && done_lvl && cfg_serial_clock_fall) begin
        falls_q <= falls_q + 2'd1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drivers, all registered
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sts_drive_q <= 1'b1;
      done_drive_q <= 1'b1;
      init_drive_q <= 1'b1;
      user_q <= 1'b0;
      ceo_n_q <= 1'b1;
      byte_q <= '0;
      byte_vld_q <= 1'b0;
    end else begin
      // Request fall reaches the drivers within the 500 ns limit.
      sts_drive_q <= (state_d == PSCFG_POR) || (state_d == PSCFG_RESET)
                     || (state_d == PSCFG_ERROR);
      done_drive_q <= !((state_d == PSCFG_WAIT_EDGES) || (state_d == PSCFG_INIT)
                        || (state_d == PSCFG_USER));
      init_drive_q <= (state_d != PSCFG_USER);
      user_q <= (state_d == PSCFG_USER);
      ceo_n_q <= !((state_d == PSCFG_WAIT_EDGES) || (state_d == PSCFG_INIT)
                   || (state_d == PSCFG_USER));
      byte_vld_q <= take_bit && (bitpos_q == 3'd7);
      if (take_bit && bitpos_q == 3'd7) begin
        byte_q <= {data_lvl, shift_q[7:1]};
      end
    end
  end

  assign status_n_o = 1'b0;
  assign status_n_oe_o = sts_drive_q;
  assign cfg_done_o = 1'b0;
  assign cfg_done_oe_o = done_drive_q;
  assign init_done_o = 1'b0;
  assign init_done_oe_o = init_drive_q;
  assign user_mode_o = user_q;
  assign chain_en_n_o = ceo_n_q;
  assign cfg_byte_o = byte_q;
  assign cfg_byte_valid_o = byte_vld_q;

endmodule : pscfg_port
`default_nettype wire

// >>> logic/pscfg_pkg.sv
// Package for the passive-serial configuration port.
// Holds timing figures and their cycle counts at the 10 MHz reference clock.
package pscfg_pkg;

  // ---------------------------------------------------------------------------
  // Clock and time figures
  // ---------------------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ = 10_000_000;
  localparam int unsigned REF_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
  localparam int unsigned CF2ST0_MAX_NS = 500;
  localparam int unsigned CF2CD_MAX_NS = 500;
  localparam int unsigned STATUS_LOW_MIN_US = 45;
  localparam int unsigned STATUS_LOW_MAX_US = 230;
  localparam int unsigned CD2UM_MIN_US = 300;
  localparam int unsigned CD2UM_MAX_US = 650;
  localparam int unsigned POR_DELAY_US = 100;
  localparam int unsigned CD2CU_PERIODS = 4;

  // Least times round up, longest times round down.
  localparam int unsigned STATUS_LOW_CYC =
    (STATUS_LOW_MIN_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int unsigned CD2UM_CYC =
    (CD2UM_MIN_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int unsigned POR_CYC = (POR_DELAY_US * 1000) / REF_PERIOD_NS;
  localparam int unsigned CF2ST0_CYC = CF2ST0_MAX_NS / REF_PERIOD_NS;
  localparam int unsigned INIT_USER_CYCLES = 16;
  localparam int unsigned CD2CU_REF_CYC = CD2CU_PERIODS;
  localparam int unsigned CNT_W = 16;

  // ---------------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PSCFG_POR,
    PSCFG_RESET,
    PSCFG_LOAD,
    PSCFG_WAIT_EDGES,
    PSCFG_INIT,
    PSCFG_USER,
    PSCFG_ERROR
  } pscfg_state_t;

endpackage : pscfg_pkg

// >>> logic/pscfg_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
module pscfg_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic agree;

  // ---------------------------------------------------------------------------
  // Capture chain; only the second and third stages are compared.
  // ---------------------------------------------------------------------------
  assign agree = (s2_q == s3_q);

  // A level change counts only once two settled stages agree.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level_o = lvl_q;
  assign rise_o = agree && s3_q && !lvl_q;
  assign fall_o = agree && !s3_q && lvl_q;

endmodule : pscfg_sync
`default_nettype wire

// >>> tb/pscfg_port_monitor.sv
// Checker for the passive-serial configuration port.
// Bound into pscfg_port and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module pscfg_port_monitor #(
  parameter int unsigned POR_CYCLES = 20,
  parameter int unsigned STATUS_CYCLES = 20,
  parameter int unsigned STARTUP_CYCLES = 30
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic reconfig_req_n_i,
  input wire logic status_n_i,
  input wire logic chain_en_n_i,
  input wire logic crc_error_i,
  input wire logic status_n_oe_o,
  input wire logic cfg_done_oe_o,
  input wire logic init_done_oe_o,
  input wire logic chain_en_n_o,
  input wire logic user_mode_o,
  input wire logic cfg_byte_valid_o
);
  logic [15:0] por_q;
  logic [15:0] st_q;
  logic [15:0] dn_q;
  // The por_q and dn_q counters saturate so that a long stay in user mode cannot wrap them.
  always_ff @(posedge ref_clk_i) begin
    por_q <= srst_i ? 16'h0000 : ((por_q == 16'hffff) ? por_q : por_q + 16'h0001);
    st_q <= (srst_i || !status_n_oe_o) ? 16'h0000 : st_q + 16'h0001;
    if (cfg_done_oe_o) begin
      dn_q <= 16'h0000;
    end else if (dn_q != 16'hffff) begin
      dn_q <= dn_q + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_req_fall;
    $fell(reconfig_req_n_i);
  endsequence
  sequence s_loading;
    !status_n_oe_o && chain_en_n_o && !user_mode_o;
  endsequence
  a_req_status_low: assert property (s_req_fall |-> ##[0:5] status_n_oe_o)
    else $error("status not pulled low after request");
  a_req_done_low: assert property (s_req_fall |-> ##[0:5] cfg_done_oe_o)
    else $error("done not pulled low after request");
  a_por_hold: assert property (por_q < POR_CYCLES |-> status_n_oe_o && cfg_done_oe_o)
    else $error("status or done released during power-on delay");
  a_status_width: assert property ($fell(status_n_oe_o) |-> st_q >= STATUS_CYCLES)
    else $error("status low pulse too short");
  a_user_lines: assert property (user_mode_o |-> !status_n_oe_o && !cfg_done_oe_o)
    else $error("line held low in user mode");
  a_done_after_load: assert property ($fell(cfg_done_oe_o) |-> !chain_en_n_o)
    else $error("done released before load finished");
  a_startup_delay: assert property ($rose(user_mode_o) |-> dn_q >= STARTUP_CYCLES)
    else $error("user mode entered too early");
  a_init_user: assert property ($fell(init_done_oe_o) |-> ##[0:1] user_mode_o)
    else $error("init-done released without user mode");
  a_error_status: assert property ((crc_error_i and s_loading) |-> ##[1:3] status_n_oe_o)
    else $error("error did not pull status low");
  a_held_off: assert property (cfg_byte_valid_o |-> $past(status_n_i) && !$past(chain_en_n_i))
    else $error("byte taken while held off");
endmodule : pscfg_port_monitor
bind pscfg_port pscfg_port_monitor #(.POR_CYCLES(POR_CYCLES), .STATUS_CYCLES(STATUS_CYCLES),
  .STARTUP_CYCLES(STARTUP_CYCLES)) u_mon (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .reconfig_req_n_i(reconfig_req_n_i), .status_n_i(status_n_i), .chain_en_n_i(chain_en_n_i),
  .crc_error_i(crc_error_i), .status_n_oe_o(status_n_oe_o), .cfg_done_oe_o(cfg_done_oe_o),
  .init_done_oe_o(init_done_oe_o), .chain_en_n_o(chain_en_n_o), .user_mode_o(user_mode_o),
  .cfg_byte_valid_o(cfg_byte_valid_o));
`default_nettype wire

// >>> tb/pscfg_host_model.sv
// Behavioural configuration host: request pulse, status wait, serial stream.
// Assumes a pulled-up status wire and a start pulse given at a falling edge.
`timescale 1ns/10ps
`default_nettype none
module pscfg_host_model (
  input wire logic ref_clk_i,
  input wire logic start_i,
  input wire logic [15:0] stream_i,
  input wire logic status_w_i,
  output logic reconfig_req_n_o,
  output logic cfg_serial_clock_o,
  output logic cfg_data_o,
  output logic busy_o
);
  int n;
  initial begin
    reconfig_req_n_o = 1'b1;
    cfg_serial_clock_o = 1'b0;
    cfg_data_o = 1'b0;
    busy_o = 1'b0;
  end
  // One configuration attempt; gives up, as a host does, if status stays low.
  always @(posedge start_i) begin
    busy_o = 1'b1;
    reconfig_req_n_o = 1'b0;
    #1000 reconfig_req_n_o = 1'b1;
    #230000;
    for (n = 0; n < 3000 && status_w_i !== 1'b1; n++) @(negedge ref_clk_i);
    #2000;
    if (status_w_i === 1'b1) begin
      for (n = 0; n < 18; n++) begin
        cfg_data_o = (n < 16) ? stream_i[n[3:0]] : 1'b0;
        #400 cfg_serial_clock_o = 1'b1;
        #400 cfg_serial_clock_o = 1'b0;
      end
    end
    busy_o = 1'b0;
  end
endmodule : pscfg_host_model
`default_nettype wire

// >>> tb/pscfg_port_test.sv
// Testbench for the passive-serial configuration port.
// Host model drives the pins; the bench owns chain enable and the error flag.
`timescale 1ns/10ps
`default_nettype none
module pscfg_port_test;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic chain_en_n_i = 1'b0;
  logic crc_error_i = 1'b0;
  logic user_clk = 1'b0;
  logic go = 1'b0;
  // Start-up clock option off by default, as for cable programming.
  logic use_uclk = 1'b0;
  logic [15:0] stream = 16'h0000;
  logic req_n, sclk, sdata, busy, status_w, done_w;
  logic status_n_o, status_n_oe_o, cfg_done_o, cfg_done_oe_o, chain_en_n_o;
  logic init_done_o, init_done_oe_o, user_mode_o, cfg_byte_valid_o;
  logic [7:0] cfg_byte_o;
  logic [7:0] got_q[$];
  int num_errors = 0;
  int check_count = 0;
  // Open-drain wires with pull-ups: low only while the port drives them.
  assign status_w = status_n_oe_o ? status_n_o : 1'b1;
  assign done_w = cfg_done_oe_o ? cfg_done_o : 1'b1;
  always #50 ref_clk_i = ~ref_clk_i;
  always #500 user_clk = ~user_clk;
  // Bytes are collected mid-cycle, away from the edge that launches them.
  always @(negedge ref_clk_i) if (cfg_byte_valid_o === 1'b1) got_q.push_back(cfg_byte_o);
  pscfg_port #(.STREAM_BITS(16), .POR_CYCLES(20), .STATUS_CYCLES(20), .STARTUP_CYCLES(30),
    .INIT_CYCLES(16)) DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reconfig_req_n_i(req_n),
    .status_n_i(status_w), .status_n_o(status_n_o), .status_n_oe_o(status_n_oe_o),
    .cfg_done_i(done_w), .cfg_done_o(cfg_done_o), .cfg_done_oe_o(cfg_done_oe_o),
    .cfg_serial_clock_i(sclk), .cfg_data_i(sdata), .chain_en_n_i(chain_en_n_i),
    .chain_en_n_o(chain_en_n_o), .user_startup_clock_i(user_clk), .use_user_clock_i(use_uclk),
    .crc_error_i(crc_error_i), .init_done_o(init_done_o), .init_done_oe_o(init_done_oe_o),
    .user_mode_o(user_mode_o), .cfg_byte_o(cfg_byte_o), .cfg_byte_valid_o(cfg_byte_valid_o));
  pscfg_host_model u_host (.ref_clk_i(ref_clk_i), .start_i(go), .stream_i(stream),
    .status_w_i(status_w), .reconfig_req_n_o(req_n), .cfg_serial_clock_o(sclk),
    .cfg_data_o(sdata), .busy_o(busy));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // One host attempt; the early check times the answer to the request.
  task automatic run_load(input logic [15:0] s);
    int n;
    got_q.delete();
    @(negedge ref_clk_i);
    stream = s;
    go = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    go = 1'b0;
    check("status pulled", {7'h00, status_n_oe_o}, 8'h01);
    check("done pulled", {7'h00, cfg_done_oe_o}, 8'h01);
    // A host that waits out a held status needs about 5400 cycles.
    for (n = 0; n < 6000 && busy !== 1'b0; n++) @(negedge ref_clk_i);
    check("host finished", {7'h00, busy}, 8'h00);
    repeat (80) @(negedge ref_clk_i);
  endtask : run_load
  task automatic t_power_up();
    check("status at power-up", {7'h00, status_n_oe_o}, 8'h01);
    check("done at power-up", {7'h00, cfg_done_oe_o}, 8'h01);
    check("init at power-up", {7'h00, init_done_oe_o}, 8'h01);
    check("init level", {7'h00, init_done_o}, 8'h00);
  endtask : t_power_up
  task automatic t_config(input logic [15:0] s);
    run_load(s);
    check("byte count", 8'(got_q.size()), 8'h02);
    check("first byte", (got_q.size() > 0) ? got_q[0] : 8'h00, s[7:0]);
    check("second byte", (got_q.size() > 1) ? got_q[1] : 8'h00, s[15:8]);
    check("chain out", {7'h00, chain_en_n_o}, 8'h00);
    check("done released", {7'h00, done_w}, 8'h01);
    check("init released", {7'h00, init_done_oe_o}, 8'h00);
    check("user mode", {7'h00, user_mode_o}, 8'h01);
  endtask : t_config
  // Error during load, or load while chain enable is off: nothing is taken.
  task automatic t_refused(input logic err, input logic en_n);
    crc_error_i = err;
    chain_en_n_i = en_n;
    run_load(16'h9e17);
    check("bytes refused", 8'(got_q.size()), 8'h00);
    check("status on error", {7'h00, status_n_oe_o}, {7'h00, err});
    check("user mode off", {7'h00, user_mode_o}, 8'h00);
    crc_error_i = 1'b0;
    chain_en_n_i = 1'b0;
  endtask : t_refused
  // User start-up clock: sixteen of its 1 us periods must pass before user mode.
  task automatic t_user_clock(input logic [15:0] s);
    use_uclk = 1'b1;
    run_load(s);
    check("bytes with user clock", 8'(got_q.size()), 8'h02);
    check("done with user clock", {7'h00, done_w}, 8'h01);
    check("user mode waits for clock", {7'h00, user_mode_o}, 8'h00);
    repeat (150) @(negedge ref_clk_i);
    check("user mode via user clock", {7'h00, user_mode_o}, 8'h01);
    check("init via user clock", {7'h00, init_done_oe_o}, 8'h00);
    use_uclk = 1'b0;
  endtask : t_user_clock
  task automatic test_done();
    $display("errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // Watchdog: seven host attempts, one waiting out a held status, take about
  // 21000 cycles, well inside this span.
  initial begin
    #3000000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (2) @(negedge ref_clk_i);
    srst_i = 1'b0;
    @(negedge ref_clk_i);
    t_power_up();
    t_config(16'hc35a);
    t_config(16'h0ff1);
    t_refused(1'b1, 1'b0);
    t_config(16'h3ca5);
    t_refused(1'b0, 1'b1);
    t_config(16'h8001);
    t_user_clock(16'h5aa5);
    test_done();
  end
endmodule : pscfg_port_test
`default_nettype wire
